// ==== hw/rssc_sequencer.sv ====
`timescale 1ns/1ps
// Contract
// - Four-bit slot value 3h..Ah enables its rail at that strobe.
// - Four-bit slot values 0h..2h leave the rail unsequenced.
// - Four-bit slot values Bh..Fh leave the rail unsequenced.
// - First buck slot is bits 3-0, reset 8h.
// - Register 0x23 resets 0x75: buck4 in 7-4, buck3 in 3-0.
// - Register 0x24 resets 0x12: backup2 5-4, backup1 1-0, rest zero.
// - Two-bit backup slot 1h means strobe one, 2h strobe two.
// - Two-bit backup slot 0h or 3h leaves rail unsequenced.
// - Strobes one and two run only while freshness flag is zero.
// - Once seal is broken backup rails are never turned off; the code keeps them on at power-down only while freshness flag is one.
// - Register 0x25 resets 0x63, switch1 slot in 7-4 is 6h.
// - Gap after strobes 1-9 is 2 ms or 5 ms per bit.
// - Factor bit multiplies gaps by ten during power-down only.
module rssc_sequencer #(
    parameter int SHORT_CYC = rssc_pkg::DELAY_SHORT_CYC,
    parameter int LONG_CYC = rssc_pkg::DELAY_LONG_CYC
) (
    // Clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // Register port
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    // Sequencing control
    input wire logic power_up,
    input wire logic power_down,
    input wire logic freshness_flag,
    // Rail enables: buck1, buck3, buck4, switch1, backup1, backup2
    output logic [rssc_pkg::NUM_RAILS-1:0] rail_en,
    output logic busy
);
    if (SHORT_CYC < 1 || LONG_CYC < SHORT_CYC ||
        LONG_CYC * rssc_pkg::PD_FACTOR >= (1 << rssc_pkg::TIMER_W)) begin : g_bad_delay
        $error("delay counts out of range");
    end

    logic [7:0] delay_lo, delay_hi, buck12, buck34, backup, switch1;
    logic [7:0] next_delay_lo, next_delay_hi, next_buck12, next_buck34;
    logic [7:0] next_backup, next_switch1;
    logic unlocked, next_unlocked;
    logic [7:0] next_rdata;

    // Register file and unlock
    always_comb begin
        next_delay_lo = delay_lo;
        next_delay_hi = delay_hi;
        next_buck12 = buck12;
        next_buck34 = buck34;
        next_backup = backup;
        next_switch1 = switch1;
        next_unlocked = unlocked;
        if (reg_wr) begin
            next_unlocked = 1'b0;
            if (reg_addr == rssc_pkg::UNLOCK_ADDR) begin
                next_unlocked = (reg_wdata == rssc_pkg::UNLOCK_KEY);
            end else if (unlocked) begin
                if (reg_addr == rssc_pkg::SEQ_DELAY_LO_ADDR) begin
                    next_delay_lo = reg_wdata;
                end else if (reg_addr == rssc_pkg::SEQ_DELAY_HI_ADDR) begin
                    next_delay_hi = reg_wdata & rssc_pkg::DELAY_HI_WMASK;
                end else if (reg_addr == rssc_pkg::BUCK1_BUCK2_ADDR) begin
                    next_buck12 = reg_wdata;
                end else if (reg_addr == rssc_pkg::BUCK3_BUCK4_ADDR) begin
                    next_buck34 = reg_wdata;
                end else if (reg_addr == rssc_pkg::BACKUP_ADDR) begin
                    next_backup = reg_wdata & rssc_pkg::BACKUP_WMASK;
                end else if (reg_addr == rssc_pkg::SWITCH1_ADDR) begin
                    next_switch1 = reg_wdata;
                end
            end
        end
        next_rdata = reg_rdata;
        if (reg_rd) begin
            if (reg_addr == rssc_pkg::SEQ_DELAY_LO_ADDR) begin
                next_rdata = delay_lo;
            end else if (reg_addr == rssc_pkg::SEQ_DELAY_HI_ADDR) begin
                next_rdata = delay_hi;
            end else if (reg_addr == rssc_pkg::BUCK1_BUCK2_ADDR) begin
                next_rdata = buck12;
            end else if (reg_addr == rssc_pkg::BUCK3_BUCK4_ADDR) begin
                next_rdata = buck34;
            end else if (reg_addr == rssc_pkg::BACKUP_ADDR) begin
                next_rdata = backup;
            end else if (reg_addr == rssc_pkg::SWITCH1_ADDR) begin
                next_rdata = switch1;
            end else begin
                next_rdata = 8'h00;
            end
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            delay_lo <= rssc_pkg::DELAY_LO_RESET;
            delay_hi <= rssc_pkg::DELAY_HI_RESET;
            buck12 <= rssc_pkg::BUCK1_BUCK2_RESET;
            buck34 <= rssc_pkg::BUCK3_BUCK4_RESET;
            backup <= rssc_pkg::BACKUP_RESET;
            switch1 <= rssc_pkg::SWITCH1_RESET;
            unlocked <= 1'b0;
            reg_rdata <= 8'h00;
        end else begin
            delay_lo <= next_delay_lo;
            delay_hi <= next_delay_hi;
            buck12 <= next_buck12;
            buck34 <= next_buck34;
            backup <= next_backup;
            switch1 <= next_switch1;
            unlocked <= next_unlocked;
            reg_rdata <= next_rdata;
        end
    end

    // Slot fields per rail
    logic [3:0] buck1_slot, buck3_slot, buck4_slot, switch1_slot;
    logic [1:0] backup1_slot, backup2_slot;
    assign buck1_slot = buck12[3:0];
    assign buck3_slot = buck34[3:0];
    assign buck4_slot = buck34[7:4];
    assign switch1_slot = switch1[7:4];
    assign backup1_slot = backup[1:0];
    assign backup2_slot = backup[5:4];

    logic [3:0] strobe, next_strobe;
    logic [3:0] main_slots [rssc_pkg::NUM_MAIN];
    logic [1:0] bu_slots [2];
    logic [rssc_pkg::NUM_RAILS-1:0] ctl, hit;
    assign main_slots[0] = buck1_slot;
    assign main_slots[1] = buck3_slot;
    assign main_slots[2] = buck4_slot;
    assign main_slots[3] = switch1_slot;
    assign bu_slots[0] = backup1_slot;
    assign bu_slots[1] = backup2_slot;

    genvar gi;
    generate
        for (gi = 0; gi < rssc_pkg::NUM_RAILS; gi++) begin : g_dec
            if (gi < rssc_pkg::NUM_MAIN) begin : g_main
                rssc_slot_decode #(.SLOT_W(4)) u_dec (
                    .slot(main_slots[gi]),
                    .strobe(strobe),
                    .main_kind(1'b1),
                    .controlled(ctl[gi]),
                    .hit(hit[gi])
                );
            end else begin : g_bu
                rssc_slot_decode #(.SLOT_W(2)) u_dec (
                    .slot(bu_slots[gi-rssc_pkg::NUM_MAIN]),
                    .strobe(strobe),
                    .main_kind(1'b0),
                    .controlled(ctl[gi]),
                    .hit(hit[gi])
                );
            end
        end
    endgenerate

    // Strobe sequencer
    rssc_pkg::rssc_state_t state, next_state;
    logic down, next_down;
    logic [rssc_pkg::TIMER_W-1:0] timer, next_timer;
    logic [rssc_pkg::NUM_RAILS-1:0] next_rail_en;
    logic next_busy;
    logic [8:0] dly_bits;
    logic gap_long;
    logic [rssc_pkg::TIMER_W-1:0] gap_cyc;
    logic [3:0] first_up;
    logic [1:0] bu_mask;

    assign dly_bits = {delay_hi[0], delay_lo};
    assign first_up = freshness_flag ? 4'h3 : 4'h1;
    assign bu_mask = freshness_flag ? 2'b11 : 2'b00;

    always_comb begin
        gap_long = 1'b0;
        if (strobe >= 4'h1 && strobe <= 4'h9) begin
            gap_long = dly_bits[strobe - 4'h1];
        end
        gap_cyc = gap_long ? rssc_pkg::TIMER_W'(LONG_CYC) : rssc_pkg::TIMER_W'(SHORT_CYC);
        if (down && delay_hi[rssc_pkg::FACTOR_BIT]) begin
            gap_cyc = rssc_pkg::TIMER_W'(gap_cyc * rssc_pkg::PD_FACTOR);
        end
    end

    always_comb begin
        next_state = state;
        next_strobe = strobe;
        next_down = down;
        next_timer = timer;
        next_rail_en = rail_en;
        case (state)
            rssc_pkg::RSSC_IDLE: begin
                if (power_up) begin
                    next_down = 1'b0;
                    next_strobe = first_up;
                    next_state = rssc_pkg::RSSC_STROBE;
                end else if (power_down) begin
                    next_down = 1'b1;
                    next_strobe = 4'(rssc_pkg::NUM_STROBES);
                    next_state = rssc_pkg::RSSC_STROBE;
                end
            end
            rssc_pkg::RSSC_STROBE: begin
                if (down) begin
                    next_rail_en = rail_en & ~hit;
                    next_rail_en[5:4] = next_rail_en[5:4] | (rail_en[5:4] & bu_mask);
                end else begin
                    next_rail_en = rail_en | hit;
                end
                next_timer = gap_cyc;
                if ((!down && strobe == 4'(rssc_pkg::NUM_STROBES)) ||
                    (down && strobe == first_up)) begin
                    next_state = rssc_pkg::RSSC_IDLE;
                end else begin
                    next_state = rssc_pkg::RSSC_WAIT;
                end
            end
            rssc_pkg::RSSC_WAIT: begin
                if (timer <= rssc_pkg::TIMER_W'(1)) begin
                    next_strobe = down ? strobe - 4'h1 : strobe + 4'h1;
                    next_state = rssc_pkg::RSSC_STROBE;
                end else begin
                    next_timer = timer - rssc_pkg::TIMER_W'(1);
                end
            end
            default: begin
                next_state = rssc_pkg::RSSC_IDLE;
            end
        endcase
        next_busy = (next_state != rssc_pkg::RSSC_IDLE);
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            state <= rssc_pkg::RSSC_IDLE;
            strobe <= 4'h0;
            down <= 1'b0;
            timer <= '0;
            rail_en <= '0;
            busy <= 1'b0;
        end else begin
            state <= next_state;
            strobe <= next_strobe;
            down <= next_down;
            timer <= next_timer;
            rail_en <= next_rail_en;
            busy <= next_busy;
        end
    end

    // Checks
    chk_locked_write: assert property (@(posedge clk) disable iff (!reset_n)
        (reg_wr && !unlocked && reg_addr == rssc_pkg::BUCK3_BUCK4_ADDR) |=> $stable(buck34))
        else $error("locked write changed slot register");
    chk_backup_zero: assert property (@(posedge clk) disable iff (!reset_n)
        (backup & ~rssc_pkg::BACKUP_WMASK) == 8'h00)
        else $error("backup reserved bits set");
    chk_unsequenced_stays_off: assert property (@(posedge clk) disable iff (!reset_n)
        (state == rssc_pkg::RSSC_STROBE && !down && !rail_en[0] &&
        (buck1_slot > rssc_pkg::MAIN_SLOT_MAX || buck1_slot < rssc_pkg::MAIN_SLOT_MIN))
        |=> !rail_en[0])
        else $error("unsequenced rail turned on");
    chk_main_enable: assert property (@(posedge clk) disable iff (!reset_n)
        (state == rssc_pkg::RSSC_STROBE && !down && strobe == buck3_slot &&
        buck3_slot >= rssc_pkg::MAIN_SLOT_MIN) |=> rail_en[1])
        else $error("buck3 not enabled at its strobe");
    chk_early_skip: assert property (@(posedge clk) disable iff (!reset_n)
        (state == rssc_pkg::RSSC_STROBE && !down && freshness_flag) |-> strobe >= 4'h3)
        else $error("early strobe run with seal broken");
    chk_backup_hold: assert property (@(posedge clk) disable iff (!reset_n)
        (freshness_flag && rail_en[4]) |=> rail_en[4])
        else $error("backup rail turned off after seal");
    sequence s_strobe_up;
        state == rssc_pkg::RSSC_STROBE && !down && strobe != 4'(rssc_pkg::NUM_STROBES);
    endsequence
    chk_gap_short: assert property (@(posedge clk) disable iff (!reset_n)
        (s_strobe_up and !gap_long) |=> timer == rssc_pkg::TIMER_W'(SHORT_CYC))
        else $error("short gap count wrong");
    chk_up_factor: assert property (@(posedge clk) disable iff (!reset_n)
        (s_strobe_up and gap_long) |=> timer == rssc_pkg::TIMER_W'(LONG_CYC))
        else $error("power-up gap scaled");
    chk_strobe_ascending: assert property (@(posedge clk) disable iff (!reset_n)
        (state == rssc_pkg::RSSC_WAIT && !down && timer == rssc_pkg::TIMER_W'(1))
        |=> strobe == $past(strobe) + 4'h1)
        else $error("strobe not ascending");
endmodule : rssc_sequencer

// ==== inc/rssc_pkg.sv ====
package rssc_pkg;
    // Register offsets and reset values
    localparam logic [7:0] SEQ_DELAY_LO_ADDR = 8'h20;
    localparam logic [7:0] SEQ_DELAY_HI_ADDR = 8'h21;
    localparam logic [7:0] BUCK1_BUCK2_ADDR = 8'h22;
    localparam logic [7:0] BUCK3_BUCK4_ADDR = 8'h23;
    localparam logic [7:0] BACKUP_ADDR = 8'h24;
    localparam logic [7:0] SWITCH1_ADDR = 8'h25;
    localparam logic [7:0] UNLOCK_ADDR = 8'h7D;
    localparam logic [7:0] UNLOCK_KEY = 8'h5A;
    localparam logic [7:0] DELAY_LO_RESET = 8'h00;
    localparam logic [7:0] DELAY_HI_RESET = 8'h00;
    localparam logic [7:0] BUCK1_BUCK2_RESET = 8'h98;
    localparam logic [7:0] BUCK3_BUCK4_RESET = 8'h75;
    localparam logic [7:0] BACKUP_RESET = 8'h12;
    localparam logic [7:0] SWITCH1_RESET = 8'h63;
    // Writable masks
    localparam logic [7:0] BACKUP_WMASK = 8'h33;
    localparam logic [7:0] DELAY_HI_WMASK = 8'h81;
    localparam int FACTOR_BIT = 7;
    // Slot decode bounds
    localparam logic [3:0] MAIN_SLOT_MIN = 4'h3;
    localparam logic [3:0] MAIN_SLOT_MAX = 4'hA;
    localparam logic [1:0] BACKUP_SLOT_MIN = 2'h1;
    localparam logic [1:0] BACKUP_SLOT_MAX = 2'h2;
    localparam int NUM_STROBES = 10;
    localparam int NUM_MAIN = 4;
    localparam int NUM_RAILS = 6;
    // Timing
    localparam int CLK_MHZ = 100;
    localparam int DELAY_SHORT_MS = 2;
    localparam int DELAY_LONG_MS = 5;
    localparam int PD_FACTOR = 10;
    localparam int DELAY_SHORT_CYC = DELAY_SHORT_MS * CLK_MHZ * 1000;
    localparam int DELAY_LONG_CYC = DELAY_LONG_MS * CLK_MHZ * 1000;
    localparam int TIMER_W = 26;
    typedef enum logic [1:0] {RSSC_IDLE, RSSC_STROBE, RSSC_WAIT} rssc_state_t;
endpackage : rssc_pkg

// ==== hw/rssc_slot_decode.sv ====
`timescale 1ns/1ps
module rssc_slot_decode #(
    parameter int SLOT_W = 4
) (
    // Slot field and current strobe
    input wire logic [SLOT_W-1:0] slot,
    input wire logic [3:0] strobe,
    input wire logic main_kind,
    // Decoded results
    output logic controlled,
    output logic hit
);
    if (SLOT_W != 4 && SLOT_W != 2) begin : g_bad_width
        $error("slot width must be 2 or 4");
    end
    logic [3:0] wide;
    always_comb begin
        wide = 4'h0;
        wide[SLOT_W-1:0] = slot;
        if (main_kind) begin
            controlled = (wide >= rssc_pkg::MAIN_SLOT_MIN) &&
                (wide <= rssc_pkg::MAIN_SLOT_MAX);
        end else begin
            controlled = (wide[1:0] >= rssc_pkg::BACKUP_SLOT_MIN) &&
                (wide[1:0] <= rssc_pkg::BACKUP_SLOT_MAX) && (wide[3:2] == 2'h0);
        end
        hit = controlled && (wide == strobe);
    end
endmodule : rssc_slot_decode

// ==== tb/rail_strobe_slot_config_test.sv ====
`timescale 1ns/1ps
module rail_strobe_slot_config_test;
    // Clock and reset
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    // Register port
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic [7:0] reg_rdata;
    // Sequencing control and rails
    logic power_up = 1'b0;
    logic power_down = 1'b0;
    logic freshness_flag = 1'b0;
    logic [rssc_pkg::NUM_RAILS-1:0] rail_en;
    logic busy;
    int n_errors = 0;
    int n_compared = 0;
    int rise [6];
    int a_len, b_len, c_len, d_len;
    logic [7:0] rv;

    localparam int SHORT = 4;
    localparam int LONG = 10;

    rssc_sequencer #(.SHORT_CYC(SHORT), .LONG_CYC(LONG)) u_rssc_sequencer (
        .clk(clk), .reset_n(reset_n), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .power_up(power_up), .power_down(power_down), .freshness_flag(freshness_flag),
        .rail_en(rail_en), .busy(busy)
    );

    initial begin
        forever #5 clk = ~clk;
    end

    task automatic final_report;
        $display("compared %0d, errors %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : final_report

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_errors++;
            $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic do_reset;
        @(posedge clk);
        reset_n <= 1'b0;
        repeat (2) @(posedge clk);
        reset_n <= 1'b1;
    endtask : do_reset

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask : wr

    // Unlock and protected write back to back
    task automatic uwr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= 8'h7D;
        reg_wdata <= 8'h5A;
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask : uwr

    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        @(posedge clk);
        #1 d = reg_rdata;
    endtask : rd

    // Runs one sequence, records the cycle each rail first reads high
    task automatic run_seq(input logic up, output int len);
        int n;
        n = 0;
        for (int i = 0; i < 6; i++) rise[i] = -1;
        @(posedge clk);
        if (up) power_up <= 1'b1;
        else power_down <= 1'b1;
        @(posedge clk);
        power_up <= 1'b0;
        power_down <= 1'b0;
        #1;
        while (busy === 1'b1 && n < 5000) begin
            @(posedge clk);
            #1 n++;
            for (int i = 0; i < 6; i++) if (rail_en[i] === 1'b1 && rise[i] < 0) rise[i] = n;
        end
        check(busy, 1'b0);
        if (n >= 5000 || n == 0) begin
            check(n, 32'hFFFF_FFFF);
            final_report();
        end
        len = n;
    endtask : run_seq

    task automatic test_registers;
        do_reset();
        rd(8'h22, rv);
        check(rv & 8'h0F, 8'h08);
        rd(8'h23, rv);
        check(rv, 8'h75);
        rd(8'h24, rv);
        check(rv, 8'h12);
        rd(8'h25, rv);
        check(rv, 8'h63);
        rd(8'h30, rv);
        check(rv, 8'h00);
        wr(8'h23, 8'h11);
        rd(8'h23, rv);
        check(rv, 8'h75);
        wr(8'h7D, 8'h5A);
        wr(8'h30, 8'h00);
        wr(8'h23, 8'h11);
        rd(8'h23, rv);
        check(rv, 8'h75);
        uwr(8'h24, 8'hFF);
        rd(8'h24, rv);
        check(rv, 8'h33);
        uwr(8'h21, 8'hFF);
        rd(8'h21, rv);
        check(rv, 8'h81);
        uwr(8'h23, 8'h4A);
        rd(8'h23, rv);
        check(rv, 8'h4A);
    endtask : test_registers

    task automatic test_order_delay;
        do_reset();
        uwr(8'h23, 8'h43);
        uwr(8'h25, 8'h53);
        uwr(8'h20, 8'h04);
        run_seq(1'b1, a_len);
        check(rail_en, 6'h3F);
        check(rise[5] < rise[4], 1);
        check(rise[4] < rise[1], 1);
        check((rise[2] - rise[1]) - (rise[3] - rise[2]), LONG - SHORT);
        check(rise[3] < rise[0], 1);
    endtask : test_order_delay

    task automatic test_seal;
        do_reset();
        freshness_flag <= 1'b1;
        run_seq(1'b1, a_len);
        check(rail_en, 6'h0F);
        do_reset();
        freshness_flag <= 1'b0;
        run_seq(1'b1, a_len);
        check(rail_en, 6'h3F);
        freshness_flag <= 1'b1;
        run_seq(1'b0, a_len);
        check(rail_en, 6'h30);
        freshness_flag <= 1'b0;
        run_seq(1'b0, a_len);
        check(rail_en, 6'h00);
    endtask : test_seal

    task automatic test_factor;
        do_reset();
        run_seq(1'b1, a_len);
        run_seq(1'b0, b_len);
        uwr(8'h21, 8'h80);
        run_seq(1'b1, c_len);
        run_seq(1'b0, d_len);
        check(c_len, a_len);
        check(d_len - b_len, 9 * (10 * SHORT - SHORT));
    endtask : test_factor

    task automatic test_decode;
        for (int v = 0; v < 16; v++) begin
            do_reset();
            uwr(8'h22, {4'h9, 4'(v)});
            run_seq(1'b1, a_len);
            check(rail_en[0], (v >= 3 && v <= 10));
        end
        for (int v = 0; v < 4; v++) begin
            do_reset();
            uwr(8'h24, {6'b000100, 2'(v)});
            run_seq(1'b1, a_len);
            check(rail_en[4], (v == 1 || v == 2));
        end
    endtask : test_decode

    initial begin
        repeat (2) @(posedge clk);
        reset_n <= 1'b1;
        test_registers();
        test_order_delay();
        test_seal();
        test_factor();
        test_decode();
        final_report();
    end
endmodule : rail_strobe_slot_config_test
